// [hw/cpb_pkg.sv]
// constants and types shared by the context packet builder
package cpb_pkg;

  // =========================================================
  // register offsets (byte addresses, one aligned word each)
  localparam logic [7:0] CPB_OFF_CTRL = 8'h00;
  localparam logic [7:0] CPB_OFF_STATUS = 8'h04;
  localparam logic [7:0] CPB_OFF_SECONDS = 8'h08;
  localparam logic [7:0] CPB_OFF_REFSEL = 8'h0C;
  localparam logic [7:0] CPB_OFF_FREQ_HI = 8'h10;
  localparam logic [7:0] CPB_OFF_FREQ_LO = 8'h14;
  localparam logic [7:0] CPB_OFF_GAIN = 8'h18;
  localparam logic [7:0] CPB_OFF_TEMP = 8'h1C;
  localparam logic [7:0] CPB_OFF_BW_HI = 8'h20;
  localparam logic [7:0] CPB_OFF_BW_LO = 8'h24;
  localparam logic [7:0] CPB_OFF_OFS_HI = 8'h28;
  localparam logic [7:0] CPB_OFF_OFS_LO = 8'h2C;
  localparam logic [7:0] CPB_OFF_REFLVL = 8'h30;
  localparam logic [7:0] CPB_OFF_SEQ = 8'h34;

  // =========================================================
  // control register bit positions
  localparam int CPB_CTRL_SEND_RX = 0;
  localparam int CPB_CTRL_SEND_DG = 1;
  localparam int CPB_CTRL_FULL_RX = 2;
  localparam int CPB_CTRL_FULL_DG = 3;

  // =========================================================
  // fixed header fields
  localparam logic [3:0] CPB_PKT_KIND = 4'h4;
  localparam logic CPB_CLASS_ID_PRESENT = 1'b0;
  localparam logic [1:0] CPB_HDR_RSVD = 2'h0;
  localparam logic CPB_TIMESTAMP_MODE_BIT = 1'b0;
  localparam logic [1:0] CPB_INTEGER_TIMESTAMP_KIND = 2'h1;
  localparam logic [1:0] CPB_FRACTIONAL_TIMESTAMP_KIND = 2'h2;
  localparam logic [31:0] CPB_SID_RX = 32'h90000001;
  localparam logic [31:0] CPB_SID_DG = 32'h09000002;

  // =========================================================
  // reference point codes
  localparam logic [31:0] CPB_ANTENNA_PORT_ONE = 32'h01000001;
  localparam logic [31:0] CPB_ANTENNA_PORT_TWO = 32'h01000002;
  localparam logic [31:0] CPB_INTERNAL_CAL = 32'h01000004;
  localparam logic [1:0] CPB_REFSEL_PORT_ONE = 2'h0;
  localparam logic [1:0] CPB_REFSEL_PORT_TWO = 2'h1;

  // =========================================================
  // indicator word bit positions
  localparam int CPB_IND_CHANGE = 31;
  localparam int CPB_IND_RX_REF = 30;
  localparam int CPB_IND_RX_FREQ = 27;
  localparam int CPB_IND_RX_GAIN = 23;
  localparam int CPB_IND_RX_TEMP = 18;
  localparam int CPB_IND_DG_BW = 29;
  localparam int CPB_IND_DG_OFS = 26;
  localparam int CPB_IND_DG_LVL = 24;

  // =========================================================
  // packet geometry
  localparam int CPB_HDR_WORDS = 6;
  localparam int CPB_FLD_WORDS = 5;
  localparam int CPB_PKT_WORDS = CPB_HDR_WORDS + CPB_FLD_WORDS;
  localparam int CPB_RX_FIELDS = 4;
  localparam int CPB_DG_FIELDS = 3;

  // =========================================================
  // timekeeping and reset values
  localparam int CPB_CLK_PERIOD_NS = 50;
  localparam int CPB_PS_PER_NS = 1000;
  localparam logic [39:0] CPB_PS_STEP =
    40'(CPB_CLK_PERIOD_NS * CPB_PS_PER_NS);
  localparam logic [39:0] CPB_PS_PER_SEC = 40'hE8_D4A5_1000;
  localparam logic [3:0] CPB_SEQ_RST = 4'h0;
  localparam logic [31:0] CPB_SECONDS_RST = 32'h0000_0000;

  typedef enum logic {
    CPB_ST_IDLE = 1'b0,
    CPB_ST_SEND = 1'b1
  } cpb_state_t;

endpackage

// [hw/cpb_stream_track.sv]
// per-stream change tracking and packet sequence count
`timescale 1ns/1ps
module cpb_stream_track
  import cpb_pkg::*;
#(
  parameter int N = 4
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [N-1:0] set_i,
  input wire logic take_i,
  output logic [N-1:0] pend_o,
  output logic [3:0] seq_o
);

  logic [N-1:0] pend_q;
  logic [N-1:0] pend_d;
  logic [3:0] seq_q;

  // a value written in the capture cycle stays pending for the next packet
  assign pend_d = (take_i ? '0 : pend_q) | set_i; // [R01]

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_q <= '0;
      seq_q <= CPB_SEQ_RST; // [R15]
    end
    else
    begin
      pend_q <= pend_d;
      if (take_i)
        seq_q <= seq_q + 4'h1; // [R15] [R28]
    end
  end

  assign pend_o = pend_q;
  assign seq_o = seq_q;

endmodule // cpb_stream_track

// [hw/cpb_context_packet_builder.sv]
// receiver and digitizer context packet builder with apb registers
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Summary of operation
// R01: change flag set lists changed fields
// R02: change flag clear means nothing changed
// R03: reference point coded per selected source
// R04: rf frequency as two fixed-point words
// R05: if gain high half, rf gain low
// R06: gains are signed 9.7 decibel values
// R07: temperature signed, six fraction bits
// R08: temperature upper half driven zero
// R09: packet kind code is 0100
// R10: no class identifier, bit cleared
// R11: reserved header bits are 00
// R12: timestamp mode bit cleared
// R13: integer timestamp kind is 01
// R14: fractional timestamp kind is 10
// R15: four-bit sequence count wraps at 1111
// R16: length covers whole packet
// R17: digitizer stream identifier 0x9000002
// R18: seconds word counts utc seconds
// R19: picoseconds since seconds last advanced
// R20: digitizer flags at 31, 29, 26, 24
// R21: fields follow flag order downward
// R22: digitizer field sizes 2, 2, 1
// R23: length counted in 32-bit words
// R24: words sent msb first
// R25: receiver stream identifier 0x90000001
// R26: receiver field sizes 1, 2, 1, 1
// R27: receiver flags at 31, 30, 27, 23, 18
// R28: separate sequence count per stream
module cpb_context_packet_builder
  import cpb_pkg::*;
#(
  parameter logic [39:0] PS_PER_SEC = CPB_PS_PER_SEC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic out_valid,
  output logic [31:0] out_data,
  output logic out_first,
  output logic out_last,
  output logic out_stream
);

  // =========================================================
  // apb decode
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;
  logic [31:0] rd_word;
  wire setup = psel & ~penable;
  wire wr_en = psel & penable & pready_q & pwrite;
  wire hit_ctrl = (paddr == CPB_OFF_CTRL);
  wire hit_status = (paddr == CPB_OFF_STATUS);
  wire hit_seconds = (paddr == CPB_OFF_SECONDS);
  wire hit_refsel = (paddr == CPB_OFF_REFSEL);
  wire hit_freq_hi = (paddr == CPB_OFF_FREQ_HI);
  wire hit_freq_lo = (paddr == CPB_OFF_FREQ_LO);
  wire hit_gain = (paddr == CPB_OFF_GAIN);
  wire hit_temp = (paddr == CPB_OFF_TEMP);
  wire hit_bw_hi = (paddr == CPB_OFF_BW_HI);
  wire hit_bw_lo = (paddr == CPB_OFF_BW_LO);
  wire hit_ofs_hi = (paddr == CPB_OFF_OFS_HI);
  wire hit_ofs_lo = (paddr == CPB_OFF_OFS_LO);
  wire hit_reflvl = (paddr == CPB_OFF_REFLVL);
  wire hit_seq = (paddr == CPB_OFF_SEQ);
  wire mapped = hit_ctrl | hit_status | hit_seconds | hit_refsel |
    hit_freq_hi | hit_freq_lo | hit_gain | hit_temp | hit_bw_hi |
    hit_bw_lo | hit_ofs_hi | hit_ofs_lo | hit_reflvl | hit_seq;
  // unmapped writes are dropped; only a mapped write reaches a register
  wire w_ctrl = wr_en & hit_ctrl;
  wire w_seconds = wr_en & hit_seconds;
  wire w_refsel = wr_en & hit_refsel;
  wire w_freq_hi = wr_en & hit_freq_hi;
  wire w_freq_lo = wr_en & hit_freq_lo;
  wire w_gain = wr_en & hit_gain;
  wire w_temp = wr_en & hit_temp;
  wire w_bw_hi = wr_en & hit_bw_hi;
  wire w_bw_lo = wr_en & hit_bw_lo;
  wire w_ofs_hi = wr_en & hit_ofs_hi;
  wire w_ofs_lo = wr_en & hit_ofs_lo;
  wire w_reflvl = wr_en & hit_reflvl;

  // =========================================================
  // context value registers
  logic full_rx_q;
  logic full_dg_q;
  logic req_rx_q;
  logic req_dg_q;
  logic [1:0] refsel_q;
  logic [63:0] freq_q;
  logic [31:0] gain_q;
  logic [15:0] temp_q;
  logic [63:0] bw_q;
  logic [63:0] ofs_q;
  logic [15:0] lvl_q;
  logic [31:0] seconds_q;
  logic [39:0] ps_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      full_rx_q <= 1'b0;
      full_dg_q <= 1'b0;
      refsel_q <= CPB_REFSEL_PORT_ONE;
      freq_q <= 64'h0;
      gain_q <= 32'h0;
      temp_q <= 16'h0;
      bw_q <= 64'h0;
      ofs_q <= 64'h0;
      lvl_q <= 16'h0;
    end
    else
    begin
      if (w_ctrl)
      begin
        full_rx_q <= pwdata[CPB_CTRL_FULL_RX];
        full_dg_q <= pwdata[CPB_CTRL_FULL_DG];
      end
      if (w_refsel) refsel_q <= pwdata[1:0];
      if (w_freq_hi) freq_q[63:32] <= pwdata; // [R04]
      if (w_freq_lo) freq_q[31:0] <= pwdata; // [R04]
      if (w_gain) gain_q <= pwdata; // [R05] [R06]
      if (w_temp) temp_q <= pwdata[15:0]; // [R07]
      if (w_bw_hi) bw_q[63:32] <= pwdata;
      if (w_bw_lo) bw_q[31:0] <= pwdata;
      if (w_ofs_hi) ofs_q[63:32] <= pwdata;
      if (w_ofs_lo) ofs_q[31:0] <= pwdata;
      if (w_reflvl) lvl_q <= pwdata[15:0];
    end
  end

  // =========================================================
  // utc seconds and picoseconds since the last second
  // writing seconds restarts the fraction so the pair stays coherent
  wire [39:0] ps_next = ps_q + CPB_PS_STEP;
  wire ps_wrap = (ps_next >= PS_PER_SEC);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      seconds_q <= CPB_SECONDS_RST;
      ps_q <= 40'h0;
    end
    else if (w_seconds)
    begin
      seconds_q <= pwdata; // [R18]
      ps_q <= 40'h0;
    end
    else if (ps_wrap)
    begin
      seconds_q <= seconds_q + 32'h1; // [R18]
      ps_q <= ps_next - PS_PER_SEC; // [R19]
    end
    else
      ps_q <= ps_next; // [R19]
  end

  // =========================================================
  // change tracking, one tracker per stream
  cpb_state_t state_q;
  logic [CPB_RX_FIELDS-1:0] rx_pend;
  logic [CPB_DG_FIELDS-1:0] dg_pend;
  logic [3:0] rx_seq;
  logic [3:0] dg_seq;
  wire idle = (state_q == CPB_ST_IDLE);
  // receiver has priority when both streams are requested together
  wire cap_rx = idle & req_rx_q;
  wire cap_dg = idle & ~req_rx_q & req_dg_q;
  wire cap = cap_rx | cap_dg;
  wire [CPB_RX_FIELDS-1:0] rx_set =
    {w_temp, w_gain, w_freq_hi | w_freq_lo, w_refsel}; // [R01]
  wire [CPB_DG_FIELDS-1:0] dg_set =
    {w_reflvl, w_ofs_hi | w_ofs_lo, w_bw_hi | w_bw_lo}; // [R01]

  cpb_stream_track #(.N(CPB_RX_FIELDS)) u_rx_track (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(rx_set),
    .take_i(cap_rx),
    .pend_o(rx_pend),
    .seq_o(rx_seq)
  );

  cpb_stream_track #(.N(CPB_DG_FIELDS)) u_dg_track (
    .pclk(pclk),
    .presetn(presetn),
    .set_i(dg_set),
    .take_i(cap_dg),
    .pend_o(dg_pend),
    .seq_o(dg_seq)
  );

  // send requests: a new request in the capture cycle is kept
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      req_rx_q <= 1'b0;
      req_dg_q <= 1'b0;
    end
    else
    begin
      req_rx_q <= (req_rx_q & ~cap_rx) |
        (w_ctrl & pwdata[CPB_CTRL_SEND_RX]);
      req_dg_q <= (req_dg_q & ~cap_dg) |
        (w_ctrl & pwdata[CPB_CTRL_SEND_DG]);
    end
  end

  // =========================================================
  // packet assembly for the stream being captured
  // full mode adds unchanged fields; the change flag still tracks pend
  wire [CPB_RX_FIELDS-1:0] rx_fld = full_rx_q ? '1 : rx_pend;
  wire [CPB_DG_FIELDS-1:0] dg_fld = full_dg_q ? '1 : dg_pend;
  wire rx_change = |rx_pend; // [R01] [R02]
  wire dg_change = |dg_pend; // [R01] [R02]
  wire [31:0] ref_word = (refsel_q == CPB_REFSEL_PORT_ONE) ?
    CPB_ANTENNA_PORT_ONE : (refsel_q == CPB_REFSEL_PORT_TWO) ?
    CPB_ANTENNA_PORT_TWO : CPB_INTERNAL_CAL; // [R03]
  logic [31:0] rx_w [CPB_FLD_WORDS];
  logic [31:0] dg_w [CPB_FLD_WORDS];
  // field slots already in flag order, most significant first
  assign rx_w[0] = ref_word; // [R21] [R26]
  assign rx_w[1] = freq_q[63:32]; // [R04]
  assign rx_w[2] = freq_q[31:0]; // [R04]
  assign rx_w[3] = gain_q; // [R05]
  assign rx_w[4] = {16'h0000, temp_q}; // [R07] [R08]
  assign dg_w[0] = bw_q[63:32]; // [R21] [R22]
  assign dg_w[1] = bw_q[31:0];
  assign dg_w[2] = ofs_q[63:32];
  assign dg_w[3] = ofs_q[31:0];
  assign dg_w[4] = {16'h0000, lvl_q};
  wire [CPB_FLD_WORDS-1:0] rx_wmask =
    {rx_fld[3], rx_fld[2], rx_fld[1], rx_fld[1], rx_fld[0]}; // [R26]
  wire [CPB_FLD_WORDS-1:0] dg_wmask =
    {dg_fld[2], dg_fld[1], dg_fld[1], dg_fld[0], dg_fld[0]}; // [R22]
  wire [CPB_FLD_WORDS-1:0] cap_wmask = cap_rx ? rx_wmask : dg_wmask;

  logic [31:0] rx_ind;
  logic [31:0] dg_ind;
  logic [2:0] fld_cnt;
  always_comb
  begin
    rx_ind = 32'h0;
    rx_ind[CPB_IND_CHANGE] = rx_change; // [R27]
    rx_ind[CPB_IND_RX_REF] = rx_fld[0]; // [R27]
    rx_ind[CPB_IND_RX_FREQ] = rx_fld[1]; // [R27]
    rx_ind[CPB_IND_RX_GAIN] = rx_fld[2]; // [R27]
    rx_ind[CPB_IND_RX_TEMP] = rx_fld[3]; // [R27]
    dg_ind = 32'h0;
    dg_ind[CPB_IND_CHANGE] = dg_change; // [R20]
    dg_ind[CPB_IND_DG_BW] = dg_fld[0]; // [R20]
    dg_ind[CPB_IND_DG_OFS] = dg_fld[1]; // [R20]
    dg_ind[CPB_IND_DG_LVL] = dg_fld[2]; // [R20]
    fld_cnt = 3'h0;
    for (int i = 0; i < CPB_FLD_WORDS; i++)
      fld_cnt = fld_cnt + {2'h0, cap_wmask[i]};
  end

  // length in words: headers, indicator and every field word
  wire [15:0] pkt_len =
    16'(CPB_HDR_WORDS) + {13'h0000, fld_cnt}; // [R16] [R23]
  wire [31:0] hdr_word = {CPB_PKT_KIND, // [R09]
    CPB_CLASS_ID_PRESENT, // [R10]
    CPB_HDR_RSVD, // [R11]
    CPB_TIMESTAMP_MODE_BIT, // [R12]
    CPB_INTEGER_TIMESTAMP_KIND, // [R13]
    CPB_FRACTIONAL_TIMESTAMP_KIND, // [R14]
    cap_rx ? rx_seq : dg_seq, // [R15]
    pkt_len}; // [R16]
  wire [31:0] sid_word = cap_rx ? CPB_SID_RX : CPB_SID_DG; // [R17] [R25]

  // =========================================================
  // snapshot and word-by-word emission
  // a snapshot keeps apb writes during a packet from tearing it
  logic [31:0] snap_q [CPB_PKT_WORDS];
  logic [CPB_PKT_WORDS-1:0] rem_q;
  logic first_q;
  logic stream_q;
  logic [CPB_PKT_WORDS-1:0] pick;
  logic [31:0] pick_word;
  assign pick = rem_q & (~rem_q + 11'h001); // [R21]
  wire [CPB_PKT_WORDS-1:0] rem_next = rem_q & ~pick;

  always_comb
  begin
    pick_word = 32'h0;
    for (int i = 0; i < CPB_PKT_WORDS; i++)
      pick_word = pick_word | (snap_q[i] & {32{pick[i]}});
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < CPB_PKT_WORDS; i++)
        snap_q[i] <= 32'h0;
    end
    else if (cap)
    begin
      snap_q[0] <= hdr_word;
      snap_q[1] <= sid_word;
      snap_q[2] <= seconds_q; // [R18]
      snap_q[3] <= {24'h000000, ps_q[39:32]}; // [R19]
      snap_q[4] <= ps_q[31:0]; // [R19]
      snap_q[5] <= cap_rx ? rx_ind : dg_ind;
      for (int i = 0; i < CPB_FLD_WORDS; i++)
        snap_q[CPB_HDR_WORDS + i] <= cap_rx ? rx_w[i] : dg_w[i];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= CPB_ST_IDLE;
      rem_q <= '0;
      first_q <= 1'b0;
      stream_q <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        CPB_ST_IDLE:
        begin
          if (cap)
          begin
            state_q <= CPB_ST_SEND;
            rem_q <= {cap_wmask, 6'h3F}; // [R22] [R26]
            first_q <= 1'b1;
            stream_q <= cap_dg;
          end
        end
        CPB_ST_SEND:
        begin
          rem_q <= rem_next;
          first_q <= 1'b0;
          if (rem_next == '0)
            state_q <= CPB_ST_IDLE;
        end
      endcase
    end
  end

  // =========================================================
  // registered outputs
  logic out_valid_q;
  logic [31:0] out_data_q;
  logic out_first_q;
  logic out_last_q;
  logic out_stream_q;
  wire sending = (state_q == CPB_ST_SEND);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_valid_q <= 1'b0;
      out_data_q <= 32'h0;
      out_first_q <= 1'b0;
      out_last_q <= 1'b0;
      out_stream_q <= 1'b0;
    end
    else
    begin
      out_valid_q <= sending;
      out_data_q <= sending ? pick_word : 32'h0; // [R24]
      out_first_q <= sending & first_q;
      out_last_q <= sending & (rem_next == '0);
      out_stream_q <= stream_q;
    end
  end

  // =========================================================
  // apb read path, zero wait states
  assign rd_word =
    ({32{hit_ctrl}} & {28'h0, full_dg_q, full_rx_q, 2'h0}) |
    ({32{hit_status}} & {21'h0, sending, req_dg_q, req_rx_q,
      1'b0, dg_pend, rx_pend}) |
    ({32{hit_seconds}} & seconds_q) |
    ({32{hit_refsel}} & {30'h0, refsel_q}) |
    ({32{hit_freq_hi}} & freq_q[63:32]) |
    ({32{hit_freq_lo}} & freq_q[31:0]) |
    ({32{hit_gain}} & gain_q) |
    ({32{hit_temp}} & {16'h0, temp_q}) |
    ({32{hit_bw_hi}} & bw_q[63:32]) |
    ({32{hit_bw_lo}} & bw_q[31:0]) |
    ({32{hit_ofs_hi}} & ofs_q[63:32]) |
    ({32{hit_ofs_lo}} & ofs_q[31:0]) |
    ({32{hit_reflvl}} & {16'h0, lvl_q}) |
    ({32{hit_seq}} & {24'h0, dg_seq, rx_seq});

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      prdata_q <= (setup & ~pwrite) ? rd_word : 32'h0;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign out_valid = out_valid_q;
  assign out_data = out_data_q;
  assign out_first = out_first_q;
  assign out_last = out_last_q;
  assign out_stream = out_stream_q;

endmodule // cpb_context_packet_builder

// [bench/cpb_monitor.sv]
// port checker for the context packet builder
`timescale 1ns/1ps
module cpb_monitor
  import cpb_pkg::*;
#(
  parameter logic [39:0] PS_PER_SEC = CPB_PS_PER_SEC
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic out_valid,
  input wire logic [31:0] out_data,
  input wire logic out_first,
  input wire logic out_last,
  input wire logic out_stream
);
  // ==========
  // word position in packet, last count seen per stream
  logic [15:0] pos_q;
  logic [15:0] len_q;
  logic [3:0] seq_q [2];

  // count starts at f so the first packet must carry 0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pos_q <= 16'h0000;
      len_q <= 16'h0000;
      seq_q <= '{4'hF, 4'hF};
    end
    else if (out_valid && out_first)
    begin
      pos_q <= 16'h0001;
      len_q <= out_data[15:0];
      seq_q[out_stream] <= out_data[19:16];
    end
    else if (out_valid)
    begin
      pos_q <= pos_q + 16'h0001;
    end
  end

  // ==========
  // properties
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_hdr;
    out_valid && out_first;
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_hdr_fixed: assert property (
    s_hdr |-> out_data[31:20] == 12'h406) else $error("bad fixed header");
  a_stream_id: assert property (s_hdr |=> out_valid &&
    out_data == (out_stream ? 32'h09000002 : 32'h90000001))
    else $error("bad stream id");
  a_len_bound: assert property (s_hdr |->
    out_data[15:0] >= 16'h6 && out_data[15:0] <= 16'hB)
    else $error("length out of range");
  a_last_at_len: assert property (out_valid && out_last |->
    !out_first && pos_q == len_q - 16'h0001) else $error("length mismatch");
  a_no_gap: assert property (out_valid && !out_last |=>
    out_valid && !out_first) else $error("gap inside packet");
  a_seq_step: assert property (s_hdr |->
    out_data[19:16] == seq_q[out_stream] + 4'h1) else $error("bad count");
  a_idle_zero: assert property (!out_valid |->
    out_data == 32'h0 && !out_first && !out_last) else $error("idle noise");
  a_stream_hold: assert property (out_valid && !out_first |->
    $stable(out_stream)) else $error("stream changed in packet");
endmodule // cpb_monitor

bind cpb_context_packet_builder cpb_monitor #(.PS_PER_SEC(PS_PER_SEC)) mon_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .out_valid(out_valid),
  .out_data(out_data), .out_first(out_first), .out_last(out_last),
  .out_stream(out_stream));

// [bench/cpb_host_model.sv]
// host model collecting the context packet stream
`timescale 1ns/1ps
module cpb_host_model (
  input wire logic pclk,
  input wire logic out_valid,
  input wire logic [31:0] out_data,
  input wire logic out_last,
  input wire logic out_stream
);
  // ==========
  // takes every word: the stream has no back-pressure
  logic [32:0] words [$];
  int npkt = 0;

  always @(posedge pclk)
  begin
    if (out_valid === 1'b1)
    begin
      words.push_back({out_stream, out_data});
      if (out_last === 1'b1)
        npkt++;
    end
  end
endmodule // cpb_host_model

// [bench/cpb_context_packet_builder_tb.sv]
// self-checking bench for the context packet builder
`timescale 1ns/1ps
module cpb_context_packet_builder_tb
  import cpb_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, out_data, rd;
  logic pready, pslverr, out_valid, out_first, out_last, out_stream, er;
  logic [31:0] sec_base = 32'h0;
  logic [31:0] exp_q [$];
  int err_total = 0;
  int n_compared = 0;
  int got_pkts = 0;

  always #25 pclk = ~pclk;

  // ==========
  // ten clocks to a second keeps the timestamp rollover in reach
  cpb_context_packet_builder #(.PS_PER_SEC(40'h7A120)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .out_valid(out_valid),
    .out_data(out_data), .out_first(out_first), .out_last(out_last),
    .out_stream(out_stream));
  cpb_host_model host_u (.pclk(pclk), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_stream(out_stream));

  // ==========
  // shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("FAIL %0t got %h want %h", $time, got, exp);
    end
  endtask

  // read compares data with d; every transfer checks the error flag
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic ee);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    chk(32'(k), 32'h1);
    chk({31'h0, er}, {31'h0, ee});
    if (!w)
      chk(rd, d);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 1'b0);
  endtask

  // exp_q holds indicator and fields; header words worked out here
  task get_pkt(input logic s, input logic [3:0] sq);
    int j, n;
    logic [32:0] w;
    n = 5 + exp_q.size();
    // a packet that never comes is left to the watchdog
    while (host_u.npkt <= got_pkts)
      @(posedge pclk);
    got_pkts++;
    for (j = 0; j < n; j++)
    begin
      w = host_u.words.pop_front();
      chk({31'h0, w[32]}, {31'h0, s});
      case (j)
        0: chk(w[31:0], {12'h406, sq, 16'(n)});
        1: chk(w[31:0], s ? 32'h09000002 : 32'h90000001);
        2: chk({31'h0, w[31:0] >= sec_base}, 32'h1);
        3: chk(w[31:0], 32'h0);
        4: chk({31'h0, w[31:0] < 32'h7A120 &&
          w[31:0] % 32'hC350 == 32'h0}, 32'h1);
        default: chk(w[31:0], exp_q[j - 5]);
      endcase
    end
    chk(32'(host_u.words.size()), 32'h0);
    exp_q.delete();
  endtask

  // ==========
  // scenarios
  task t_regs;
    bus(1'b0, CPB_OFF_STATUS, 32'h0, 1'b0);
    bus(1'b0, CPB_OFF_SEQ, 32'h0, 1'b0);
    bus(1'b0, 8'h3C, 32'h0, 1'b1);
    bus(1'b0, 8'h02, 32'h0, 1'b1);
    bus(1'b1, 8'h3C, 32'hFFFFFFFF, 1'b1);
    wr(CPB_OFF_CTRL, 32'hC);
    bus(1'b0, CPB_OFF_CTRL, 32'hC, 1'b0);
    wr(CPB_OFF_CTRL, 32'h0);
    $display("done regs");
  endtask

  task t_rx;
    sec_base = 32'h12345678;
    wr(CPB_OFF_SECONDS, sec_base);
    wr(CPB_OFF_REFSEL, 32'h1);
    wr(CPB_OFF_FREQ_HI, 32'h1);
    wr(CPB_OFF_FREQ_LO, 32'h23400000);
    wr(CPB_OFF_GAIN, 32'hFF800100);
    wr(CPB_OFF_TEMP, 32'hFFFFFFC0);
    bus(1'b0, CPB_OFF_STATUS, 32'hF, 1'b0);
    wr(CPB_OFF_CTRL, 32'h1);
    exp_q = {32'hC8840000, 32'h01000002, 32'h1, 32'h23400000,
      32'hFF800100, 32'h0000FFC0};
    get_pkt(1'b0, 4'h0);
    bus(1'b0, CPB_OFF_SEQ, 32'h1, 1'b0);
    $display("done receiver");
  endtask

  // one send word asks for both streams: receiver first, no changes
  task t_dg;
    wr(CPB_OFF_BW_HI, 32'h123);
    wr(CPB_OFF_BW_LO, 32'h45600000);
    bus(1'b0, CPB_OFF_STATUS, 32'h10, 1'b0);
    wr(CPB_OFF_CTRL, 32'h2);
    exp_q = {32'hA0000000, 32'h123, 32'h45600000};
    get_pkt(1'b1, 4'h0);
    wr(CPB_OFF_CTRL, 32'h3);
    exp_q = {32'h0};
    get_pkt(1'b0, 4'h1);
    exp_q = {32'h0};
    get_pkt(1'b1, 4'h1);
    $display("done digitizer");
  endtask

  task t_full;
    wr(CPB_OFF_OFS_LO, 32'h00800000);
    wr(CPB_OFF_REFLVL, 32'hFFFFFF80);
    wr(CPB_OFF_CTRL, 32'hA);
    exp_q = {32'hA5000000, 32'h123, 32'h45600000, 32'h0,
      32'h00800000, 32'h0000FF80};
    get_pkt(1'b1, 4'h2);
    // full receiver packet with nothing changed: fields but no change flag
    wr(CPB_OFF_CTRL, 32'h5);
    exp_q = {32'h48840000, 32'h01000002, 32'h1, 32'h23400000,
      32'hFF800100, 32'h0000FFC0};
    get_pkt(1'b0, 4'h2);
    wr(CPB_OFF_CTRL, 32'h0);
    $display("done full");
  endtask

  // all source codes, and the count runs through its wrap
  task t_wrap;
    int i;
    logic [31:0] code [4];
    code = '{32'h01000001, 32'h01000002, 32'h01000004, 32'h01000004};
    for (i = 0; i < 16; i++)
    begin
      wr(CPB_OFF_REFSEL, 32'(i % 4));
      wr(CPB_OFF_CTRL, 32'h1);
      exp_q = {32'hC0000000, code[i % 4]};
      get_pkt(1'b0, 4'((i + 3) % 16));
    end
    $display("done wrap");
  endtask

  task close_out;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs;
    t_rx;
    t_dg;
    t_full;
    t_wrap;
    close_out;
  end

  initial
  begin
    repeat (6000) @(posedge pclk);
    err_total++;
    close_out;
  end
endmodule // cpb_context_packet_builder_tb
